// ---- include/fcpc_pkg.sv ----
package fcpc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_SETTING = 8'h08;
    localparam int ADDR_W = 8;
    // status bit positions
    localparam int ST_VSHORT = 0;
    localparam int ST_IOPEN = 1;
    localparam int ST_TEMP = 2;
    localparam int ST_PEC = 3;
    localparam int ST_MODE = 4;
    // control bit positions
    localparam int CT_CLR_SEL = 0;
    localparam int CT_SENSE = 1;
    localparam int CT_CLR_CMD = 2;
    localparam int CT_OUT_EN = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [11:0] SETTING_RST = 12'h000;
    // serial word: bit 15 picks the target, low bits carry data
    localparam int WD_TARGET = 15;
    localparam logic [4:0] LEN_DATA = 5'h10;
    localparam logic [4:0] LEN_PEC = 5'h18;
    localparam logic [4:0] LEN_OVER = 5'h19;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // clear codes
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MID = 12'h800;
    // synchroniser lanes
    localparam int SY_SCLK = 0;
    localparam int SY_SDIN = 1;
    localparam int SY_SYNC = 2;
    localparam int SY_CLR = 3;
    localparam int SY_CSEL = 4;
    localparam int SY_FI = 5;
    localparam int SY_FV = 6;
    localparam int SY_FT = 7;
    localparam int SY_MODE = 8;
    localparam int SY_W = 9;
    localparam logic [8:0] SY_RST = 9'h004;
    // edges after reset that capture the strap; the lane carries the pin from the third
    localparam logic [1:0] MODE_WAIT = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mode_hw;
        logic [1:0] mode_wait;
        logic sclk_d;
        logic sync_d;
        logic [4:0] cnt;
        logic [23:0] sh;
        logic [7:0] crc;
        logic [3:0] ctrl;
        logic [11:0] setting;
        logic pec_err;
        logic [11:0] out_code;
        logic clr_act;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fcpc_state_t;
endpackage : fcpc_pkg

// ---- hw/fcpc_sync.sv ----
`timescale 1ns/1ps
module fcpc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // lanes
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fcpc_sy_t;

    fcpc_sy_t st;
    fcpc_sy_t next_st;

    always_comb begin
        next_st.s1 = i_d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= {RST, RST};
        end else begin
            st <= next_st;
        end
    end

    assign o_q = st.s2;
endmodule : fcpc_sync

// ---- hw/fcpc_top.sv ----
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// RL1: software mode: any fault pulls combined alert
// RL2: alerts are open drain, pull low only
// RL3: packet check failure is a software fault
// RL4: hardware mode uses three dedicated alerts
// RL5: hardware mode: current fault pulls its alert
// RL6: hardware mode: voltage short pulls its alert
// RL7: hardware mode: overtemperature pulls its alert
// RL8: active high clear forces clear value
// RL9: clear select is pin OR bit
// RL10: select 0 bottom, select 1 midscale
// RL11: current output clears to range bottom
// RL12: after clear, newest setting returns
// RL13: control clear command also clears output
// RL14: sense resistor choice from loaded bit
// RL15: host computes CRC-8 poly 0x07
// RL16: host sends 24 bits before sync rises
// RL17: 24-bit frame checked at sync rise
// RL18: good check writes the selected register
// RL19: bad check discards, alerts, sets flag
// RL20: status read clears packet error flag
// RL21: plain frame is 16 bits, falling edge
// RL22: mode strap picks hardware or software
// RL23: 16 bits unchecked, other lengths ignored
// RL24: CRC msb first, zero init, no inversion
module fcpc_top (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // serial link from host
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic i_sync_n,
    // clear and strap pins
    input wire logic i_clear,
    input wire logic i_clear_value_select,
    input wire logic i_control_mode_select,
    // fault detectors
    input wire logic i_current_open_fault,
    input wire logic i_voltage_short_fault,
    input wire logic i_over_temp_fault,
    // open-drain alert pins
    output logic o_fault_alert_n_out,
    output logic o_fault_alert_n_oe_n,
    output logic o_current_open_alert_n_out,
    output logic o_current_open_alert_n_oe_n,
    output logic o_voltage_short_alert_n_out,
    output logic o_voltage_short_alert_n_oe_n,
    output logic o_temp_alert_n_out,
    output logic o_temp_alert_n_oe_n,
    // output stage control
    output logic [11:0] o_out_code,
    output logic o_clear_active,
    output logic o_sense_res_select,
    output logic o_out_enable,
    // axi4-lite write
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    fcpc_pkg::fcpc_state_t s;
    fcpc_pkg::fcpc_state_t next_s;
    logic [8:0] sy;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic len16;
    logic len24;
    logic crc_ok;
    logic good;
    logic bad;
    logic [15:0] word;
    logic clr_on;
    logic clr_sel;
    logic wr_go;
    logic rd_go;
    logic st_rd;
    logic any_fault;
    logic [15:0] wmask;

    fcpc_sync #(
        .W(fcpc_pkg::SY_W),
        .RST(fcpc_pkg::SY_RST)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_d({i_control_mode_select, i_over_temp_fault,
              i_voltage_short_fault, i_current_open_fault,
              i_clear_value_select, i_clear, i_sync_n,
              i_sdin, i_sclk}),
        .o_q(sy)
    );

    // msb-first crc step, zero start, no inversion
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic b);
        logic fb;
        fb = c[7] ^ b;
        return {c[6:0], 1'b0} ^ (fb ? fcpc_pkg::CRC_POLY : 8'h00);
    endfunction : crc_step

    assign sclk_fall = s.sclk_d & ~sy[fcpc_pkg::SY_SCLK];
    assign sync_fall = s.sync_d & ~sy[fcpc_pkg::SY_SYNC];
    assign sync_rise = ~s.sync_d & sy[fcpc_pkg::SY_SYNC];
    assign len16 = s.cnt == fcpc_pkg::LEN_DATA;
    assign len24 = s.cnt == fcpc_pkg::LEN_PEC;
    assign crc_ok = s.crc == s.sh[7:0];
    assign word = len24 ? s.sh[23:8] : s.sh[15:0];
    // RL17 check at sync
    assign good = sync_rise & (len16 | (len24 & crc_ok));
    assign bad = sync_rise & len24 & ~crc_ok;
    // RL9 or of selects
    assign clr_sel = sy[fcpc_pkg::SY_CSEL]
                   | s.ctrl[fcpc_pkg::CT_CLR_SEL];
    // RL13 command clear
    assign clr_on = sy[fcpc_pkg::SY_CLR]
                  | s.ctrl[fcpc_pkg::CT_CLR_CMD];
    assign wr_go = s.aw_have & s.w_have & ~s.bvalid;
    assign rd_go = i_arvalid & ~s.rvalid;
    assign st_rd = rd_go & (i_araddr == fcpc_pkg::REG_STATUS);
    assign wmask = {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    // RL1 any fault
    assign any_fault = s.pec_err | sy[fcpc_pkg::SY_FI]
                     | sy[fcpc_pkg::SY_FV] | sy[fcpc_pkg::SY_FT];

    always_comb begin
        next_s = s;
        // RL22 strap capture
        // the synchroniser shows its reset value for two edges
        if (s.mode_wait != fcpc_pkg::MODE_WAIT) begin
            next_s.mode_wait = s.mode_wait + 2'h1;
            next_s.mode_hw = sy[fcpc_pkg::SY_MODE];
        end
        next_s.sclk_d = sy[fcpc_pkg::SY_SCLK];
        next_s.sync_d = sy[fcpc_pkg::SY_SYNC];
        if (sync_fall) begin
            next_s.cnt = 5'h00;
            next_s.crc = fcpc_pkg::CRC_INIT;
        end else if (!sy[fcpc_pkg::SY_SYNC] && sclk_fall) begin
            // RL21 sample on falling edge
            next_s.sh = {s.sh[22:0], sy[fcpc_pkg::SY_SDIN]};
            if (s.cnt < fcpc_pkg::LEN_OVER) begin
                next_s.cnt = s.cnt + 5'h01;
            end
            // RL24 crc over data bits
            if (s.cnt < fcpc_pkg::LEN_DATA) begin
                next_s.crc = crc_step(s.crc, sy[fcpc_pkg::SY_SDIN]);
            end
        end
        // bus write lands first so a serial frame wins
        if (wr_go) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = fcpc_pkg::RESP_OKAY;
            case (s.awaddr)
                fcpc_pkg::REG_CTRL: begin
                    next_s.ctrl = (s.ctrl & ~wmask[3:0])
                                | (s.wdata[3:0] & wmask[3:0]);
                end
                fcpc_pkg::REG_SETTING: begin
                    next_s.setting = (s.setting & ~wmask[11:0])
                                   | (s.wdata[11:0] & wmask[11:0]);
                end
                default: begin
                    next_s.bresp = fcpc_pkg::RESP_SLVERR;
                end
            endcase
        end else begin
            if (s.bvalid && i_bready) begin
                next_s.bvalid = 1'b0;
            end
            if (i_awvalid && o_awready) begin
                next_s.aw_have = 1'b1;
                next_s.awaddr = i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                next_s.w_have = 1'b1;
                next_s.wdata = i_wdata;
                next_s.wstrb = i_wstrb;
            end
        end
        // RL18 write selected register
        // RL23 other lengths ignored
        if (good) begin
            if (word[fcpc_pkg::WD_TARGET]) begin
                next_s.setting = word[11:0];
            end else begin
                next_s.ctrl = word[3:0];
            end
        end
        // RL20 read clears flag
        if (st_rd) begin
            next_s.pec_err = 1'b0;
        end
        // RL19 flag bad frame
        if (bad) begin
            next_s.pec_err = 1'b1;
        end
        if (s.rvalid && i_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = fcpc_pkg::RESP_OKAY;
            case (i_araddr)
                fcpc_pkg::REG_STATUS: begin
                    next_s.rdata = {27'h000_0000, s.mode_hw, s.pec_err,
                                    sy[fcpc_pkg::SY_FT],
                                    sy[fcpc_pkg::SY_FI],
                                    sy[fcpc_pkg::SY_FV]};
                end
                fcpc_pkg::REG_CTRL: begin
                    next_s.rdata = {28'h000_0000, s.ctrl};
                end
                fcpc_pkg::REG_SETTING: begin
                    next_s.rdata = {20'h0_0000, s.setting};
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = fcpc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // RL8 clear forces value
        // RL10 select picks code
        // RL11 code zero is range bottom
        // RL12 release to setting
        next_s.clr_act = clr_on;
        if (clr_on) begin
            next_s.out_code = clr_sel ? fcpc_pkg::CODE_MID
                                      : fcpc_pkg::CODE_ZERO;
        end else begin
            next_s.out_code = s.setting;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
            s.sclk_d <= 1'b0;
            s.sync_d <= 1'b1;
            s.crc <= fcpc_pkg::CRC_INIT;
            s.ctrl <= fcpc_pkg::CTRL_RST;
            s.setting <= fcpc_pkg::SETTING_RST;
            s.out_code <= fcpc_pkg::CODE_ZERO;
        end else begin
            s <= next_s;
        end
    end

    // RL2 pins only pull low
    assign o_fault_alert_n_out = 1'b0;
    assign o_current_open_alert_n_out = 1'b0;
    assign o_voltage_short_alert_n_out = 1'b0;
    assign o_temp_alert_n_out = 1'b0;
    // RL1 combined alert
    // RL3 packet error counts
    assign o_fault_alert_n_oe_n = ~(~s.mode_hw & any_fault);
    // RL4 dedicated alerts
    // RL5 current alert
    assign o_current_open_alert_n_oe_n =
        ~(s.mode_hw & sy[fcpc_pkg::SY_FI]);
    // RL6 voltage alert
    assign o_voltage_short_alert_n_oe_n =
        ~(s.mode_hw & sy[fcpc_pkg::SY_FV]);
    // RL7 temperature alert
    assign o_temp_alert_n_oe_n = ~(s.mode_hw & sy[fcpc_pkg::SY_FT]);

    assign o_out_code = s.out_code;
    assign o_clear_active = s.clr_act;
    // RL14 sense resistor bit
    assign o_sense_res_select = s.ctrl[fcpc_pkg::CT_SENSE];
    assign o_out_enable = s.ctrl[fcpc_pkg::CT_OUT_EN];
    assign o_awready = ~s.aw_have & ~s.bvalid;
    assign o_wready = ~s.w_have & ~s.bvalid;
    assign o_bvalid = s.bvalid;
    assign o_bresp = s.bresp;
    assign o_arready = ~s.rvalid;
    assign o_rvalid = s.rvalid;
    assign o_rdata = s.rdata;
    assign o_rresp = s.rresp;

    a_sw_combined: // RL1
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        !s.mode_hw && any_fault |-> !o_fault_alert_n_oe_n)
        else $error("combined alert not pulled");
    a_open_drain: // RL2
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        !o_fault_alert_n_out && !o_temp_alert_n_out
        && !o_current_open_alert_n_out && !o_voltage_short_alert_n_out)
        else $error("alert pin driven high");
    a_pec_alert: // RL3
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        bad && !s.mode_hw |=> !o_fault_alert_n_oe_n)
        else $error("packet error did not alert");
    a_hw_no_combined: // RL4
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        s.mode_hw |-> o_fault_alert_n_oe_n)
        else $error("combined alert used in hardware mode");
    a_hw_current: // RL5
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        s.mode_hw |-> o_current_open_alert_n_oe_n
                      == !sy[fcpc_pkg::SY_FI])
        else $error("current alert mismatch");
    a_hw_voltage: // RL6
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        s.mode_hw |-> o_voltage_short_alert_n_oe_n
                      == !sy[fcpc_pkg::SY_FV])
        else $error("voltage alert mismatch");
    a_hw_temp: // RL7
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        s.mode_hw |-> o_temp_alert_n_oe_n == !sy[fcpc_pkg::SY_FT])
        else $error("temperature alert mismatch");
    a_clear_value: // RL10
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        clr_on |=> o_clear_active && o_out_code
            == ($past(clr_sel) ? fcpc_pkg::CODE_MID
                               : fcpc_pkg::CODE_ZERO))
        else $error("wrong clear value");
    a_clear_release: // RL12
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        !clr_on |=> o_out_code == $past(s.setting))
        else $error("output did not return to setting");
    a_pec_discard: // RL19
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        bad && !wr_go
        |=> s.pec_err && $stable(s.setting) && $stable(s.ctrl))
        else $error("bad frame not discarded");
    a_pec_write: // RL18
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        good && word[fcpc_pkg::WD_TARGET]
        |=> s.setting == $past(word[11:0]))
        else $error("good frame not written");
    a_status_clear: // RL20
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        st_rd && !bad |=> !s.pec_err)
        else $error("status read kept packet flag");
    a_odd_length: // RL23
    assert property (@(posedge i_mclk) disable iff (!i_arst_n)
        sync_rise && !len16 && !len24 && !wr_go
        |=> $stable(s.setting) && $stable(s.ctrl))
        else $error("odd frame length accepted");
endmodule : fcpc_top

// ---- test/fcpc_host_model.sv ----
`timescale 1ns/1ps
module fcpc_host_model (
    // serial link to device
    output logic o_sclk,
    output logic o_sdin,
    output logic o_sync_n
);
    initial begin
        o_sclk = 1'b1;
        o_sdin = 1'b0;
        o_sync_n = 1'b1;
    end

    function automatic logic [7:0] fcpc_crc8(input logic [15:0] d);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : fcpc_crc8

    // bad flips the check byte lsb to force a failed check
    task automatic send(input logic [15:0] w, input int n, input logic bad);
        logic [23:0] f;
        f = {w, fcpc_crc8(w) ^ {7'h00, bad}};
        o_sync_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            o_sdin = f[23 - i];
            #40 o_sclk = 1'b0;
            #40 o_sclk = 1'b1;
        end
        #40 o_sync_n = 1'b1;
        // released data line shows the inverse of the last bit
        o_sdin = ~o_sdin;
        #80;
    endtask : send
endmodule : fcpc_host_model

// ---- test/fcpc_tb_top.sv ----
`timescale 1ns/1ps
module fcpc_tb_top;
    logic i_mclk, i_arst_n, i_sclk, i_sdin, i_sync_n;
    logic i_clear, i_clear_value_select, i_control_mode_select;
    logic i_current_open_fault, i_voltage_short_fault, i_over_temp_fault;
    logic [3:0] oe_n, al_out;
    logic [11:0] o_out_code;
    logic o_clear_active, o_sense_res_select, o_out_enable;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic i_arvalid, o_arready, o_rvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp;
    int err_count, tests_run;
    logic [31:0] stb [3];

    fcpc_host_model fcpc_host_model_i (.o_sclk(i_sclk), .o_sdin(i_sdin),
        .o_sync_n(i_sync_n));

    fcpc_top fcpc_top_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_sclk(i_sclk), .i_sdin(i_sdin), .i_sync_n(i_sync_n),
        .i_clear(i_clear), .i_clear_value_select(i_clear_value_select),
        .i_control_mode_select(i_control_mode_select),
        .i_current_open_fault(i_current_open_fault),
        .i_voltage_short_fault(i_voltage_short_fault),
        .i_over_temp_fault(i_over_temp_fault),
        .o_fault_alert_n_out(al_out[3]), .o_fault_alert_n_oe_n(oe_n[3]),
        .o_current_open_alert_n_out(al_out[2]),
        .o_current_open_alert_n_oe_n(oe_n[2]),
        .o_voltage_short_alert_n_out(al_out[1]),
        .o_voltage_short_alert_n_oe_n(oe_n[1]),
        .o_temp_alert_n_out(al_out[0]), .o_temp_alert_n_oe_n(oe_n[0]),
        .o_out_code(o_out_code), .o_clear_active(o_clear_active),
        .o_sense_res_select(o_sense_res_select), .o_out_enable(o_out_enable),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(3'h0),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
        .o_rresp(o_rresp));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic aw, w, b, ta, tw;
        logic [1:0] r;
        int n;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        n = 0;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!b && n < 100) begin
            @(negedge i_mclk);
            ta = aw & o_awready;
            tw = w & o_wready;
            b = o_bvalid;
            r = o_bresp;
            @(posedge i_mclk);
            if (ta) begin
                aw = 1'b0;
                i_awvalid <= 1'b0;
            end
            if (tw) begin
                w = 1'b0;
                i_wvalid <= 1'b0;
            end
            n++;
        end
        i_bready <= 1'b0;
        @(posedge i_mclk);
        check("bvalid", 32'h0000_0001, 32'(b));
        check("bresp", 32'(er), 32'(r));
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        logic ar, rv, ta;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        ar = 1'b1;
        rv = 1'b0;
        n = 0;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (!rv && n < 100) begin
            @(negedge i_mclk);
            ta = ar & o_arready;
            rv = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_mclk);
            if (ta) begin
                ar = 1'b0;
                i_arvalid <= 1'b0;
            end
            n++;
        end
        i_rready <= 1'b0;
        @(posedge i_mclk);
        check("rvalid", 32'h0000_0001, 32'(rv));
        check("rdata", e, d);
        check("rresp", 32'(er), 32'(r));
    endtask : bus_rd

    task automatic settle(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : settle

    task automatic serial(input logic [15:0] w, input int n, input logic bad);
        fcpc_host_model_i.send(w, n, bad);
        settle(6);
    endtask : serial

    task automatic alerts(input logic [3:0] e);
        check("alert_oe_n", 32'(e), 32'(oe_n));
        check("alert_out", 32'h0000_0000, 32'(al_out));
    endtask : alerts

    task automatic reset_dut();
        i_arst_n <= 1'b0;
        settle(12);
        i_arst_n <= 1'b1;
        settle(2);
    endtask : reset_dut

    task automatic fault_loop(input logic hw);
        for (int i = 0; i < 3; i++) begin
            {i_current_open_fault, i_voltage_short_fault,
             i_over_temp_fault} <= 3'b100 >> i;
            settle(4);
            alerts(hw ? 4'hf & ~(4'b0100 >> i) : 4'h7);
            bus_rd(fcpc_pkg::REG_STATUS, stb[i] | {27'h0, hw, 4'h0},
                   fcpc_pkg::RESP_OKAY);
            {i_current_open_fault, i_voltage_short_fault,
             i_over_temp_fault} <= 3'b000;
            settle(4);
            alerts(4'hf);
        end
    endtask : fault_loop

    initial begin
        #200_000;
        err_count++;
        print_verdict();
    end

    initial begin
        stb = '{32'h0000_0002, 32'h0000_0001, 32'h0000_0004};
        {i_arst_n, i_clear, i_clear_value_select} = 3'b000;
        {i_control_mode_select, i_current_open_fault} = 2'b00;
        {i_voltage_short_fault, i_over_temp_fault} = 2'b00;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
        err_count = 0;
        tests_run = 0;
        reset_dut();
        bus_rd(fcpc_pkg::REG_STATUS, 32'h0000_0000, fcpc_pkg::RESP_OKAY);
        bus_rd(fcpc_pkg::REG_CTRL, 32'h0000_0000, fcpc_pkg::RESP_OKAY);
        bus_rd(fcpc_pkg::REG_SETTING, 32'h0000_0000, fcpc_pkg::RESP_OKAY);
        alerts(4'hf);
        bus_rd(8'h0c, 32'h0000_0000, fcpc_pkg::RESP_SLVERR);
        bus_wr(fcpc_pkg::REG_STATUS, 32'h0000_00ff, fcpc_pkg::RESP_SLVERR);
        serial(16'h8123, 16, 1'b0);
        bus_rd(fcpc_pkg::REG_SETTING, 32'h0000_0123, fcpc_pkg::RESP_OKAY);
        check("out_code", 32'h0000_0123, 32'(o_out_code));
        serial(16'h000a, 24, 1'b0);
        bus_rd(fcpc_pkg::REG_CTRL, 32'h0000_000a, fcpc_pkg::RESP_OKAY);
        check("sense_sel", 32'h0000_0001, 32'(o_sense_res_select));
        check("out_en", 32'h0000_0001, 32'(o_out_enable));
        serial(16'h8456, 24, 1'b1);
        alerts(4'h7);
        bus_rd(fcpc_pkg::REG_SETTING, 32'h0000_0123, fcpc_pkg::RESP_OKAY);
        bus_rd(fcpc_pkg::REG_STATUS, 32'h0000_0008, fcpc_pkg::RESP_OKAY);
        bus_rd(fcpc_pkg::REG_STATUS, 32'h0000_0000, fcpc_pkg::RESP_OKAY);
        alerts(4'hf);
        serial(16'h8777, 20, 1'b0);
        bus_rd(fcpc_pkg::REG_SETTING, 32'h0000_0123, fcpc_pkg::RESP_OKAY);
        i_clear <= 1'b1;
        settle(4);
        check("clr_zero", 32'h0000_0000, 32'(o_out_code));
        check("clr_act", 32'h0000_0001, 32'(o_clear_active));
        i_clear_value_select <= 1'b1;
        settle(4);
        check("clr_mid", 32'h0000_0800, 32'(o_out_code));
        i_clear_value_select <= 1'b0;
        bus_wr(fcpc_pkg::REG_CTRL, 32'h0000_0001, fcpc_pkg::RESP_OKAY);
        settle(3);
        check("clr_or", 32'h0000_0800, 32'(o_out_code));
        check("out_off", 32'h0000_0000, 32'(o_out_enable));
        bus_wr(fcpc_pkg::REG_SETTING, 32'h0000_02ab, fcpc_pkg::RESP_OKAY);
        i_clear <= 1'b0;
        settle(4);
        check("clr_end", 32'h0000_02ab, 32'(o_out_code));
        check("clr_off", 32'h0000_0000, 32'(o_clear_active));
        bus_wr(fcpc_pkg::REG_CTRL, 32'h0000_0004, fcpc_pkg::RESP_OKAY);
        settle(3);
        check("cmd_clr", 32'h0000_0000, 32'(o_out_code));
        bus_wr(fcpc_pkg::REG_CTRL, 32'h0000_0000, fcpc_pkg::RESP_OKAY);
        settle(3);
        check("cmd_end", 32'h0000_02ab, 32'(o_out_code));
        fault_loop(1'b0);
        i_control_mode_select <= 1'b1;
        reset_dut();
        fault_loop(1'b1);
        print_verdict();
    end
endmodule : fcpc_tb_top
